/* File: include/oneshot_pwm_timer_pkg.sv */
// Purpose: Constants and types shared by the one-shot and modulation timer.
// Assumes: Count clock prescaled from a 20 MHz system clock.
// Notes: Mode and clock select encodings are plain ports of the block.
package oneshot_pwm_timer_pkg;
  localparam int CNT_W = 16;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] PWM16_PERIOD = 16'hFFFF;
  localparam logic [7:0] PWM8_PERIOD = 8'hFF;
  localparam logic [4:0] DIV_ONE = 5'h00;
  localparam logic [4:0] DIV_EIGHT = 5'h07;
  localparam logic [4:0] DIV_THIRTYTWO = 5'h1F;
  localparam logic [1:0] CLKSEL_ONE = 2'h0;
  localparam logic [1:0] CLKSEL_EIGHT = 2'h1;
  localparam logic [1:0] CLKSEL_THIRTYTWO = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_RUN = 3'b100
  } state_t;
endpackage

/* File: include/count_tick_if.sv */
// Purpose: Carries the selected count clock tick between the modules.
// Assumes: Single clock domain.
// Notes: The tick is a one-cycle pulse, but stays high on every enabled cycle at divide by one.
`timescale 1ns/1ns
interface count_tick_if;
  logic [1:0] sel;
  logic tick;
  modport src (input sel, output tick);
  modport dst (output sel, input tick);
endinterface

/* File: logic/count_prescaler.sv */
// Purpose: Produces the selected count clock tick from the system clock.
// Assumes: Clock enable freezes the divider.
// Notes: Reserved select value falls back to divide by one.
`timescale 1ns/1ns
module count_prescaler
  import oneshot_pwm_timer_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Asynchronous reset.
  input wire logic en_i, // Clock enable.
  count_tick_if.src tk // Tick carrier.
);
  logic [4:0] div_q;
  logic [4:0] div_d;
  logic [4:0] lim;

  always_comb begin
    case (tk.sel)
      CLKSEL_EIGHT: lim = DIV_EIGHT;
      CLKSEL_THIRTYTWO: lim = DIV_THIRTYTWO;
      default: lim = DIV_ONE;
    endcase
    div_d = (div_q >= lim) ? 5'h00 : div_q + 5'h01;
    tk.tick = en_i && (div_q >= lim);
  end

  // The divider only advances while enabled.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 5'h00;
    end else if (en_i) begin
      div_q <= div_d;
    end
  end
endmodule

/* File: logic/oneshot_pwm_timer.sv */
// Purpose: One-shot and pulse width modulation modes of a down counter.
// Assumes: Trigger arrives from a pin; software strobes are synchronous.
// Notes: Timer register reads return a junk value, the inverted reload, never the count.
`timescale 1ns/1ns
// How it works
// - One-shot counts down, reloads at zero, then stops.
// - One-shot trigger while running reloads and restarts.
// - One-shot needs start flag set; trigger then starts countdown.
// - Clearing the count start flag stops the counter.
// - One-shot interrupt pulses when the count reaches zero.
// - One-shot pin is port output or pulse output as configured.
// - Timer register reads give an undefined value.
// - Write while stopped loads reload register and counter.
// - Write while counting loads only reload register.
// - Modulation reloads at output rising edge and keeps counting.
// - Modulation ignores triggers while counting.
// - 16-bit modulation: high n ticks, cycle 65535 ticks.
// - 8-bit: high n(m+1), cycle 255(m+1) ticks.
// - Modulation starts when count start flag is set.
module oneshot_pwm_timer
  import oneshot_pwm_timer_pkg::*;
#(
  parameter int W = CNT_W
)(
  input wire logic clk_i, // System clock, 20 MHz.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic en_i, // Clock enable, freezes all state when low.
  input wire logic pwm_mode_i, // 1 selects modulation, 0 one-shot.
  input wire logic pwm8_i, // 1 selects 8-bit modulation.
  input wire logic [1:0] clk_sel_i, // Count clock select.
  input wire logic pulse_out_en_i, // 1 routes the pulse to the pin.
  input wire logic port_out_i, // Value driven when used as a port.
  input wire logic count_start_i, // Count start flag level.
  input wire logic oneshot_start_i, // One-shot start flag strobe.
  input wire logic trigger_i, // External trigger pin, async.
  input wire logic wr_i, // Timer register write strobe.
  input wire logic [W-1:0] wdata_i, // Timer register write data.
  output logic [W-1:0] rdata_o, // Timer register read data.
  output logic pulse_out_pin_two_o, // Timer output pin.
  output logic irq_o // Interrupt request, one-cycle pulse.
);
  state_t st_q, st_d;
  logic [W-1:0] reload_q, reload_d, cnt_q, cnt_d;
  logic [7:0] pre_q, pre_d;
  logic [W-1:0] phase_q, phase_d;
  logic out_q, out_d, irq_q, irq_d, pin_q, pin_d;
  logic [W-1:0] rdata_q, rdata_d;
  logic trg_s1_q, trg_s2_q, trg_s3_q;
  logic trig;
  count_tick_if tk();

  assign tk.sel = clk_sel_i;
  // count clock select.
  // The divider free-runs, so the first tick after a start lands anywhere
  // within one divided period; widths are exact only at divide by one.
  count_prescaler u_pre (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .en_i (en_i),
    .tk (tk)
  );

  // Trigger pin is synchronised before the edge detect reads it.
  // The third stage only feeds the edge detect, so a trigger is seen two
  // enabled cycles after the pin rises.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
      trg_s3_q <= 1'b0;
    end else if (en_i) begin
      trg_s1_q <= trigger_i;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
    end
  end
  assign trig = trg_s2_q && !trg_s3_q;

  // Next state of the counter, reload register and output.
  always_comb begin
    st_d = st_q;
    reload_d = reload_q;
    cnt_d = cnt_q;
    pre_d = pre_q;
    phase_d = phase_q;
    out_d = out_q;
    irq_d = 1'b0;
    if (wr_i) begin
      reload_d = wdata_i;
      if (st_q != ST_RUN) begin
        cnt_d = wdata_i;
      end
    end
    case (st_q)
      ST_IDLE: begin
        // Idle: the pulse rests low until a start condition is met.
        out_d = 1'b0;
        if (!pwm_mode_i && count_start_i && oneshot_start_i) begin
          st_d = ST_ARMED;
        end
        if (pwm_mode_i && count_start_i) begin
          st_d = ST_RUN;
          cnt_d = reload_d;
          phase_d = '0;
          pre_d = 8'h00;
          out_d = (pwm8_i ? (reload_d[15:8] != 8'h00) : (reload_d != '0));
        end
      end
      ST_ARMED: begin
        // Armed: waits for a trigger edge; count ticks are ignored here.
        if (trig) begin
          st_d = ST_RUN;
          cnt_d = reload_d;
          out_d = 1'b1;
        end
      end
      ST_RUN: begin
        if (!pwm_mode_i) begin
          if (trig) begin
            cnt_d = reload_d;
          end else if (tk.tick) begin
            // A count of one or zero ends on this tick, so n gives n ticks.
            if (cnt_q <= 16'h0001) begin
              cnt_d = reload_d;
              st_d = ST_ARMED;
              out_d = 1'b0;
              irq_d = 1'b1;
            end else begin
              cnt_d = cnt_q - 16'h0001;
            end
          end
        end else if (tk.tick) begin
          // triggers are not looked at here.
          if (pwm8_i && pre_q < reload_q[7:0]) begin
            pre_d = pre_q + 8'h01;
          end else begin
            pre_d = 8'h00;
            if (phase_q >= (pwm8_i ? {8'h00, PWM8_PERIOD} : PWM16_PERIOD)
                - 16'h0001) begin
              phase_d = '0;
              cnt_d = reload_q;
              out_d = pwm8_i ? (reload_q[15:8] != 8'h00) : (reload_q != '0);
            end else begin
              phase_d = phase_q + 16'h0001;
              if (cnt_q != '0) begin
                cnt_d = cnt_q - 16'h0001;
              end
              if ((pwm8_i ? {8'h00, cnt_q[15:8]} : cnt_q) <= 16'h0001) begin
                irq_d = out_q;
                out_d = 1'b0;
              end
            end
          end
          // In 8-bit mode only the high byte counts; the low byte keeps the
          // prescale value m, and ticks inside the prescale hold the count.
          if (pwm8_i && pre_q < reload_q[7:0]) begin
            cnt_d = cnt_q;
            phase_d = phase_q;
          end else if (pwm8_i && phase_d != '0) begin
            cnt_d = {cnt_q[15:8] - ((cnt_q[15:8] != 8'h00) ? 8'h01 : 8'h00),
                     cnt_q[7:0]};
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // start flag low stops.
    // Stopping drops back to idle, so a one-shot must be armed again.
    if (!count_start_i) begin
      st_d = ST_IDLE;
      out_d = 1'b0;
    end
    // read returns junk.
    // The read port shows the inverted reload value so that software can
    // never mistake it for the live count.
    rdata_d = ~reload_d;
    pin_d = (pwm_mode_i || pulse_out_en_i) ? out_d : port_out_i;
  end

  // State registers; all frozen while the enable is low.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      reload_q <= RELOAD_RST;
      cnt_q <= CNT_RST;
      pre_q <= 8'h00;
      phase_q <= '0;
      out_q <= 1'b0;
      irq_q <= 1'b0;
      pin_q <= 1'b0;
      rdata_q <= ~RELOAD_RST;
    end else if (en_i) begin
      st_q <= st_d;
      reload_q <= reload_d;
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      phase_q <= phase_d;
      out_q <= out_d;
      irq_q <= irq_d;
      pin_q <= pin_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs come straight from flip-flops.
  assign rdata_o = rdata_q;
  assign pulse_out_pin_two_o = pin_q;
  assign irq_o = irq_q;
endmodule

/* File: test/oneshot_pwm_timer_sva.sv */
// Purpose: Concurrent checks on the timer pins and interrupt.
// Assumes: Clock enable is held high while the checks run.
// Notes: Sees only the ports of the timer top module.
`timescale 1ns/1ns
module timer_sva (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Asynchronous reset.
  input wire logic pwm_mode_i, // Mode select.
  input wire logic pulse_out_en_i, // Pin routing.
  input wire logic port_out_i, // Port value.
  input wire logic count_start_i, // Count start flag.
  input wire logic trigger_i, // Trigger pin.
  input wire logic pulse_out_pin_two_o, // Timer pin.
  input wire logic irq_o // Interrupt request.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Two low samples mean the flag clear has surely landed.
  sequence s_stopped;
    !count_start_i ##1 !count_start_i;
  endsequence
  sequence s_os_pulse;
    !pwm_mode_i && pulse_out_en_i;
  endsequence
  a_irq_one_cycle: assert property (irq_o |=> !irq_o)
    else $error("irq longer than one cycle");
  a_os_end_irq: assert property (
    s_os_pulse ##0 irq_o |-> $fell(pulse_out_pin_two_o))
    else $error("one-shot irq without pulse end");
  a_os_stays_low: assert property (
    s_os_pulse ##0 irq_o |-> !pulse_out_pin_two_o [*3])
    else $error("one-shot restarted without trigger");
  a_os_trig_cause: assert property (
    s_os_pulse ##0 $rose(pulse_out_pin_two_o) |-> $past(trigger_i, 2))
    else $error("one-shot pulse without trigger");
  a_port_follow: assert property (
    (!pwm_mode_i && !pulse_out_en_i) [*2]
    |-> pulse_out_pin_two_o == $past(port_out_i))
    else $error("pin does not follow port value");
  a_pwm_fall_irq: assert property (
    pwm_mode_i && count_start_i && $past(count_start_i)
    |-> irq_o == $fell(pulse_out_pin_two_o))
    else $error("modulation irq not at falling pulse");
  a_stop_no_irq: assert property (s_stopped |-> !irq_o)
    else $error("irq while stopped");
  a_stop_no_rise: assert property (
    pwm_mode_i throughout s_stopped |-> !$rose(pulse_out_pin_two_o))
    else $error("pulse started while stopped");
endmodule
bind oneshot_pwm_timer timer_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .pwm_mode_i(pwm_mode_i), .pulse_out_en_i(pulse_out_en_i),
  .port_out_i(port_out_i), .count_start_i(count_start_i),
  .trigger_i(trigger_i), .pulse_out_pin_two_o(pulse_out_pin_two_o),
  .irq_o(irq_o));

/* File: test/trig_src.sv */
// Purpose: Trigger source standing on the far side of the trigger pin.
// Assumes: Pin rests low; each trigger is one clean rising edge.
// Notes: Held high long enough to pass the input synchroniser.
`timescale 1ns/1ns
module trig_src (
  input wire logic clk_i, // System clock.
  output logic trigger_o // Trigger pin level.
);
  initial trigger_o = 1'b0;
  // Rises just after an edge, falls after eight clocks.
  task automatic fire();
    @(posedge clk_i) #5 trigger_o = 1'b1;
    repeat (8) @(posedge clk_i);
    #5 trigger_o = 1'b0;
  endtask
endmodule

/* File: test/oneshot_pwm_timer_bench.sv */
// Purpose: Self-checking bench for the one-shot and modulation timer.
// Assumes: Clock enable stays high; widths measured on the pin.
// Notes: Prescaler phase makes divided widths a range, not a value.
`timescale 1ns/1ns
module oneshot_pwm_timer_bench;
  import oneshot_pwm_timer_pkg::*;
  logic clk_i, rst_i, en_i, pwm_mode_i, pwm8_i, pulse_out_en_i;
  logic port_out_i, count_start_i, oneshot_start_i, trigger_i, wr_i;
  logic irq_o, pin;
  logic [1:0] clk_sel_i;
  logic [15:0] wdata_i, rdata;
  int err_count = 0, num_checks = 0, hi, per;
  oneshot_pwm_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i),
    .pwm_mode_i(pwm_mode_i), .pwm8_i(pwm8_i), .clk_sel_i(clk_sel_i),
    .pulse_out_en_i(pulse_out_en_i), .port_out_i(port_out_i),
    .count_start_i(count_start_i), .oneshot_start_i(oneshot_start_i),
    .trigger_i(trigger_i), .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata),
    .pulse_out_pin_two_o(pin), .irq_o(irq_o));
  trig_src i_trig (.clk_i(clk_i), .trigger_o(trigger_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic step(int n = 1);
    repeat (n) @(posedge clk_i);
    #5;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] v);
    wdata_i = v;
    wr_i = 1'b1;
    step();
    wr_i = 1'b0;
  endtask
  // Bounded waits so a dead pin cannot hang the run.
  task automatic measure(bit full);
    int n;
    n = 0;
    hi = 0;
    while (pin !== 1'b1 && n < 70000) begin step(); n++; end
    while (pin === 1'b1 && hi < 70000) begin step(); hi++; end
    per = hi;
    if (full) while (pin !== 1'b1 && per < 70000) begin step(); per++; end
  endtask
  task automatic t_div(logic [1:0] sel, int d, logic [15:0] n);
    clk_sel_i = sel;
    wr(n);
    fork i_trig.fire(); measure(0); join
    chk("width", 16'h0001, 16'(hi >= (n-1)*d+1 && hi <= n*d));
    $display("one-shot test done, divider %0d", d);
  endtask
  task automatic t_retrig;
    clk_sel_i = CLKSEL_ONE;
    wr(16'h0014);
    fork i_trig.fire(); measure(0); begin step(8); wr(16'h0008); end join
    chk("live write", 16'h0014, 16'(hi));
    // The read port must not track the count; it shows the inverted reload.
    chk("read value", 16'hFFF7, rdata);
    // Count 16; second edge reloads at cycle 11 of the pulse, so 11 + 16.
    wr(16'h0010);
    fork begin i_trig.fire(); step(2); i_trig.fire(); end measure(0); join
    chk("retrigger", 16'h001B, 16'(hi));
    $display("retrigger test done");
  endtask
  task automatic t_pwm(logic m8, logic [15:0] v, int eh, int ep, bit f);
    count_start_i = 1'b0;
    pwm_mode_i = 1'b1;
    pwm8_i = m8;
    step();
    wr(v);
    count_start_i = 1'b1;
    fork measure(f); i_trig.fire(); join
    chk("high time", 16'(eh), 16'(hi));
    chk("cycle time", 16'(ep), 16'(per));
    count_start_i = 1'b0;
    $display("modulation test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog: the full 16-bit cycle dominates the run of some 66200 clocks.
  initial begin
    repeat (80000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end
  initial begin
    {rst_i, en_i, pwm_mode_i, pwm8_i, pulse_out_en_i} = 5'h19;
    {port_out_i, count_start_i, oneshot_start_i, wr_i} = 4'h0;
    clk_sel_i = CLKSEL_ONE;
    wdata_i = 16'h0000;
    repeat (3) @(posedge clk_i);
    #5 rst_i = 1'b0;
    step();
    wr(16'h0005);
    count_start_i = 1'b1;
    oneshot_start_i = 1'b1;
    step();
    oneshot_start_i = 1'b0;
    t_div(CLKSEL_ONE, 1, 16'h0005);
    t_div(CLKSEL_EIGHT, 8, 16'h0003);
    t_div(CLKSEL_THIRTYTWO, 32, 16'h0002);
    t_retrig();
    t_pwm(1'b1, 16'h0301, 6, 510, 1'b1);
    t_pwm(1'b0, 16'h0004, 4, 65535, 1'b1);
    pwm_mode_i = 1'b0;
    pulse_out_en_i = 1'b0;
    port_out_i = 1'b1;
    step(2);
    chk("port high", 16'h0001, 16'(pin));
    port_out_i = 1'b0;
    step(2);
    chk("port low", 16'h0000, 16'(pin));
    $display("port test done");
    give_verdict();
  end
endmodule
